// ### hdl/mmr_regs.sv
// memory-map control register bank with mode, direct and page registers
`timescale 1ns/1ps
`default_nettype none
module mmr_regs
   import mmr_pkg::*;
#(
   parameter int PIX_W = MMR_PIX_W
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // strap and security
   input wire logic mode_pin,
   input wire logic secured,
   // register access
   input wire logic [9:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_q,
   // call/return page path
   input wire logic call_pg_wr,
   input wire logic [3:0] call_pg_wdata,
   output logic [3:0] call_pg_rdata_q,
   // translation request
   input wire logic [15:0] local_addr,
   input wire logic direct_mode,
   output logic [17:0] global_addr_q,
   output logic nvm_hit_q,
   // state
   output logic mode_select_bit_q,
   output logic [7:0] direct_page_index_q,
   output logic nvm_window_select_q,
   output logic [3:0] program_page_select_q
);
   // refused at elaboration: the page logic is fixed at four index bits
   if (PIX_W != 4)
   begin : g_bad_pix_w
      $error("mmr_regs: page index width must be 4");
   end

   logic started_q;
   logic mode_lock_q;
   logic direct_done_q;
   logic [7:0] rdata_d;
   logic [17:0] gaddr;
   logic nvm_hit;

   wire sel_mode = reg_addr == MMR_OFF_MODE;
   wire sel_direct = reg_addr == MMR_OFF_DIRECT;
   wire sel_rmap = reg_addr == MMR_OFF_RMAP;
   wire sel_program_page_select = reg_addr == MMR_OFF_PROGRAM_PAGE_SELECT;
   wire new_mode = reg_wdata[MMR_MODE_BIT];
   // only special (1) to normal (0), or same value, is allowed
   wire mode_ok = (new_mode == mode_select_bit_q)
                  || !new_mode;
   wire mode_wr = reg_wr && sel_mode && !secured
                  && !mode_lock_q && started_q;
   wire mode_bad = mode_wr && !mode_ok;
   wire direct_wr = reg_wr && sel_direct
                    && (mode_select_bit_q || !direct_done_q);
   // pin governs during reset; stored bit afterwards
   wire cur_mode = started_q ? mode_select_bit_q : mode_pin;

   // reset-time capture: async reset loads a constant, clocked capture
   // takes the pin on the first edge after release
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         started_q <= 1'b0;
      else
         started_q <= 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_select_bit_q <= 1'b0;
      else if (!started_q)
         mode_select_bit_q <= mode_pin;
      else if (mode_wr && mode_ok)
         mode_select_bit_q <= new_mode;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         mode_lock_q <= 1'b0;
      else if (mode_bad && !cur_mode)
         mode_lock_q <= 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         direct_page_index_q <= MMR_DIRECT_RST;
         direct_done_q <= 1'b0;
      end
      else if (direct_wr)
      begin
         direct_page_index_q <= reg_wdata;
         direct_done_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         nvm_window_select_q <= MMR_NVM_RST;
      else if (reg_wr && sel_rmap)
         nvm_window_select_q <= reg_wdata[MMR_NVM_BIT];
   end

   // call path wins over a bus write in the same cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         program_page_select_q <= MMR_PROGRAM_PAGE_SELECT_RST;
      else if (call_pg_wr)
         program_page_select_q <= call_pg_wdata;
      else if (reg_wr && sel_program_page_select)
         program_page_select_q <= reg_wdata[3:0];
   end

   always_comb
   begin
      rdata_d = 8'h00;
      if (sel_mode)
         rdata_d[MMR_MODE_BIT] = cur_mode;
      else if (sel_direct)
         rdata_d = direct_page_index_q;
      else if (sel_rmap)
         rdata_d[MMR_NVM_BIT] = nvm_window_select_q;
      else if (sel_program_page_select)
         rdata_d[3:0] = program_page_select_q;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_q <= 8'h00;
         call_pg_rdata_q <= MMR_PROGRAM_PAGE_SELECT_RST;
         global_addr_q <= 18'h00000;
         nvm_hit_q <= 1'b0;
      end
      else
      begin
         reg_rdata_q <= reg_rd ? rdata_d : 8'h00;
         call_pg_rdata_q <= program_page_select_q;
         global_addr_q <= gaddr;
         nvm_hit_q <= nvm_hit;
      end
   end

   mmr_xlate u_xlate (
      .local_addr(local_addr),
      .direct_mode(direct_mode),
      .direct_page_index(direct_page_index_q),
      .program_page_select(program_page_select_q),
      .nvm_window_select(nvm_window_select_q),
      .global_addr(gaddr),
      .nvm_hit(nvm_hit)
   );

   // assertions
   // sampled rst_n keeps the release edge itself, still in reset, out
   property p_capture;
      @(posedge clk) disable iff (!rst_n)
      rst_n && !started_q |=> mode_select_bit_q == $past(mode_pin);
   endproperty
   a_capture: assert property (p_capture)
      else $error("mode pin not captured at reset release");

   property p_secure;
      @(posedge clk) disable iff (!rst_n)
      started_q && secured && reg_wr && sel_mode |=> $stable(mode_select_bit_q);
   endproperty
   a_secure: assert property (p_secure)
      else $error("mode changed while secured");

   property p_no_ns_to_ss;
      @(posedge clk) disable iff (!rst_n)
      started_q && !mode_select_bit_q |=> !mode_select_bit_q;
   endproperty
   a_no_ns_to_ss: assert property (p_no_ns_to_ss)
      else $error("normal to special transition taken");

   property p_lock;
      @(posedge clk) disable iff (!rst_n)
      mode_lock_q |=> mode_lock_q && $stable(mode_select_bit_q);
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked mode bit changed");

   property p_direct_once;
      @(posedge clk) disable iff (!rst_n)
      direct_done_q && !mode_select_bit_q |=> $stable(direct_page_index_q);
   endproperty
   a_direct_once: assert property (p_direct_once)
      else $error("second direct write accepted in normal mode");

   property p_call;
      @(posedge clk) disable iff (!rst_n)
      call_pg_wr |=> program_page_select_q == $past(call_pg_wdata);
   endproperty
   a_call: assert property (p_call)
      else $error("call path page update late");

   property p_page_win;
      @(posedge clk) disable iff (!rst_n)
      !direct_mode && local_addr[15:14] == 2'h2
      |=> global_addr_q[17:14] == $past(program_page_select_q);
   endproperty
   a_page_win: assert property (p_page_win)
      else $error("paged window mapped wrong");

   property p_fixed;
      @(posedge clk) disable iff (!rst_n)
      !direct_mode && local_addr[15:14] == 2'h3
      |=> global_addr_q[17:14] == MMR_PAGE_TOP;
   endproperty
   a_fixed: assert property (p_fixed)
      else $error("top window not on fixed page");

   property p_rsvd;
      @(posedge clk) disable iff (!rst_n)
      reg_rd && (reg_addr == MMR_OFF_RSVD_A || reg_addr == MMR_OFF_RSVD_E0)
      |=> reg_rdata_q == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved location read non-zero");
endmodule // mmr_regs
`default_nettype wire

// ### hdl/mmr_pkg.sv
// constants for the memory-map control register bank
package mmr_pkg;
   localparam logic [9:0] MMR_OFF_RSVD_A = 10'h00A;
   localparam logic [9:0] MMR_OFF_MODE = 10'h00B;
   localparam logic [9:0] MMR_OFF_RSVD_B = 10'h010;
   localparam logic [9:0] MMR_OFF_DIRECT = 10'h011;
   localparam logic [9:0] MMR_OFF_RSVD_C = 10'h012;
   localparam logic [9:0] MMR_OFF_RMAP = 10'h013;
   localparam logic [9:0] MMR_OFF_RSVD_D = 10'h014;
   localparam logic [9:0] MMR_OFF_PROGRAM_PAGE_SELECT = 10'h015;
   localparam logic [9:0] MMR_OFF_RSVD_E0 = 10'h016;
   localparam logic [9:0] MMR_OFF_RSVD_E1 = 10'h017;
   localparam int MMR_MODE_BIT = 7;
   localparam int MMR_NVM_BIT = 0;
   localparam int MMR_PIX_W = 4;
   localparam logic [7:0] MMR_DIRECT_RST = 8'h00;
   localparam logic MMR_NVM_RST = 1'b0;
   localparam logic [3:0] MMR_PROGRAM_PAGE_SELECT_RST = 4'hE;
   localparam logic [3:0] MMR_PAGE_LOW = 4'hC;
   localparam logic [3:0] MMR_PAGE_MID = 4'hD;
   localparam logic [3:0] MMR_PAGE_TOP = 4'hF;
   localparam logic [1:0] MMR_WIN_PAGED = 2'h2;
   localparam logic [13:0] MMR_NVM_BASE = 14'h0004;
   localparam logic [13:0] MMR_NVM_LAST = 14'h0007;
endpackage : mmr_pkg

// ### hdl/mmr_xlate.sv
// local to global address translation
`timescale 1ns/1ps
`default_nettype none
module mmr_xlate
   import mmr_pkg::*;
(
   // request
   input wire logic [15:0] local_addr,
   input wire logic direct_mode,
   input wire logic [7:0] direct_page_index,
   input wire logic [3:0] program_page_select,
   input wire logic nvm_window_select,
   // result
   output logic [17:0] global_addr,
   output logic nvm_hit
);
   wire [15:0] eff_addr;
   wire [1:0] win;
   wire [3:0] page;
   // direct accesses take their high byte from the index
   assign eff_addr = direct_mode ? {direct_page_index, local_addr[7:0]}
                                 : local_addr;
   assign win = eff_addr[15:14];
   assign page = (win == 2'h0) ? MMR_PAGE_LOW :
                 (win == 2'h1) ? MMR_PAGE_MID :
                 (win == MMR_WIN_PAGED) ? program_page_select :
                 MMR_PAGE_TOP;
   assign global_addr = {page, eff_addr[13:0]};
   // 0x04000-0x07FFF: nvm resources when set, program flash when clear
   assign nvm_hit = nvm_window_select
      && (global_addr[17:12] >= MMR_NVM_BASE[5:0])
      && (global_addr[17:12] <= MMR_NVM_LAST[5:0]);
endmodule // mmr_xlate
`default_nettype wire

// ### testbench/mmr_cpu_model.sv
// bus-master model standing in for the cpu core and debug master
`timescale 1ns/1ps
`default_nettype none
module mmr_cpu_model
(
   // clock
   input wire logic clk,
   // register access
   output logic [9:0] reg_addr = 10'h3FF,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_wdata = 8'h00,
   input wire logic [7:0] reg_rdata_q,
   // call/return page path
   output logic call_pg_wr = 1'b0,
   output logic [3:0] call_pg_wdata = 4'h0,
   // translation request
   output logic [15:0] local_addr = 16'h0000,
   output logic direct_mode = 1'b0
);
   // strobe for one edge; data scrambled once released
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      // let the register update settle before anyone looks
      #1;
   endtask
   // read data is registered on the taking edge and sampled just after it
   task automatic rd(input logic [9:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_q;
   endtask
   // result is registered, so look just after the edge
   task automatic xl(input logic [15:0] a, input logic dm);
      @(posedge clk);
      local_addr <= a;
      direct_mode <= dm;
      @(posedge clk);
      #1;
   endtask
   // page update through the call/return side path
   task automatic cpg(input logic [3:0] p);
      @(posedge clk);
      call_pg_wdata <= p;
      call_pg_wr <= 1'b1;
      @(posedge clk);
      call_pg_wr <= 1'b0;
      call_pg_wdata <= ~p;
      #1;
   endtask
endmodule // mmr_cpu_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the memory-map control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mmr_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mode_pin = 1'b1;
   logic secured = 1'b0;
   int n_fail = 0;
   int tests_run = 0;
   logic [7:0] rv;
   wire [9:0] reg_addr;
   wire [7:0] reg_wdata, reg_rdata_q, direct_page_index_q;
   wire [3:0] call_pg_wdata, call_pg_rdata_q, program_page_select_q;
   wire [15:0] local_addr;
   wire [17:0] global_addr_q;
   wire reg_wr, reg_rd, call_pg_wr, direct_mode, nvm_hit_q;
   wire mode_select_bit_q, nvm_window_select_q;
   always #2 clk = ~clk;
   mmr_regs u_dut (.clk, .rst_n, .mode_pin, .secured, .reg_addr, .reg_wr,
      .reg_rd, .reg_wdata, .reg_rdata_q, .call_pg_wr, .call_pg_wdata,
      .call_pg_rdata_q, .local_addr, .direct_mode, .global_addr_q,
      .nvm_hit_q, .mode_select_bit_q, .direct_page_index_q,
      .nvm_window_select_q, .program_page_select_q);
   mmr_cpu_model u_cpu (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata_q, .call_pg_wr, .call_pg_wdata, .local_addr, .direct_mode);
   task automatic chk(input string nm, input logic [17:0] e,
      input logic [17:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rst(input logic pin);
      @(posedge clk);
      rst_n <= 1'b0;
      mode_pin <= pin;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      rst(1'b1);
      chk("mode", 18'h1, 18'(mode_select_bit_q));
      chk("page", 18'hE, 18'(program_page_select_q));
      chk("dir", 18'h0, 18'(direct_page_index_q));
      @(posedge clk);
      mode_pin <= 1'b0;
      u_cpu.rd(MMR_OFF_MODE, rv);
      chk("mode_rd", 18'h80, 18'(rv));
      $display("test reset done");
   endtask
   task automatic t_direct;
      u_cpu.wr(MMR_OFF_DIRECT, 8'h04);
      u_cpu.wr(MMR_OFF_DIRECT, 8'h21);
      chk("dir", 18'h21, 18'(direct_page_index_q));
      u_cpu.xl(16'hFF12, 1'b1);
      chk("dir_ga", 18'h32112, global_addr_q);
      $display("test direct done");
   endtask
   task automatic t_map;
      logic [15:0] loc[3] = '{16'h1234, 16'h4321, 16'hC555};
      logic [17:0] exp_ga[3] = '{18'h31234, 18'h34321, 18'h3C555};
      u_cpu.wr(MMR_OFF_RMAP, 8'h01);
      chk("nvm", 18'h1, 18'(nvm_window_select_q));
      u_cpu.rd(MMR_OFF_RMAP, rv);
      chk("rmap", 18'h1, 18'(rv));
      u_cpu.wr(MMR_OFF_PROGRAM_PAGE_SELECT, 8'h01);
      u_cpu.xl(16'h8000, 1'b0);
      chk("win_ga", 18'h04000, global_addr_q);
      chk("hit", 18'h1, 18'(nvm_hit_q));
      u_cpu.wr(MMR_OFF_RMAP, 8'h00);
      u_cpu.xl(16'hBFFF, 1'b0);
      chk("win_ga", 18'h07FFF, global_addr_q);
      chk("hit", 18'h0, 18'(nvm_hit_q));
      for (int i = 0; i < 3; i++)
      begin
         u_cpu.xl(loc[i], 1'b0);
         chk("fixed", exp_ga[i], global_addr_q);
      end
      $display("test map done");
   endtask
   task automatic t_call;
      u_cpu.cpg(4'h9);
      chk("page", 18'h9, 18'(program_page_select_q));
      @(posedge clk);
      #1;
      chk("call_rd", 18'h9, 18'(call_pg_rdata_q));
      u_cpu.rd(MMR_OFF_PROGRAM_PAGE_SELECT, rv);
      chk("page_rd", 18'h9, 18'(rv));
      // call path and bus write on one edge: call path wins
      fork
         u_cpu.wr(MMR_OFF_PROGRAM_PAGE_SELECT, 8'h03);
         u_cpu.cpg(4'h6);
      join
      chk("page", 18'h6, 18'(program_page_select_q));
      $display("test call done");
   endtask
   task automatic t_rsvd;
      u_cpu.wr(MMR_OFF_RSVD_A, 8'hFF);
      u_cpu.rd(MMR_OFF_RSVD_A, rv);
      chk("rsvd", 18'h0, 18'(rv));
      u_cpu.wr(MMR_OFF_PROGRAM_PAGE_SELECT, 8'hFF);
      u_cpu.rd(MMR_OFF_PROGRAM_PAGE_SELECT, rv);
      chk("page_rd", 18'hF, 18'(rv));
      u_cpu.rd(MMR_OFF_RSVD_E1, rv);
      chk("rsvd", 18'h0, 18'(rv));
      $display("test reserved done");
   endtask
   task automatic t_mode;
      @(posedge clk);
      secured <= 1'b1;
      u_cpu.wr(MMR_OFF_MODE, 8'h00);
      chk("mode", 18'h1, 18'(mode_select_bit_q));
      secured <= 1'b0;
      u_cpu.wr(MMR_OFF_MODE, 8'h00);
      chk("mode", 18'h0, 18'(mode_select_bit_q));
      u_cpu.wr(MMR_OFF_MODE, 8'h80);
      chk("mode", 18'h0, 18'(mode_select_bit_q));
      rst(1'b0);
      chk("mode", 18'h0, 18'(mode_select_bit_q));
      u_cpu.wr(MMR_OFF_DIRECT, 8'h05);
      u_cpu.wr(MMR_OFF_DIRECT, 8'h06);
      chk("dir", 18'h05, 18'(direct_page_index_q));
      $display("test mode done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      final_report;
   end
   initial
   begin
      t_reset;
      t_direct;
      t_map;
      t_call;
      t_rsvd;
      t_mode;
      final_report;
   end
endmodule // tb_top
`default_nettype wire
